// ---- logic/memory_map_pkg.sv ----
// Constants for the memory map decoder and option register.
// Assumes a 14-bit CPU address bus and an 8-bit data bus on one clock.
//
// Contract
// [RULE_01] Decode one 16-Kbyte space in both configurations.
// [RULE_02] Option register at 3FDF holds two window bits, changeable anytime; the code ignores writes to it in the alternate configuration.
// [RULE_03] High window bit read/write; 1 routes 0100-017F to RAM, else EPROM.
// [RULE_04] Default map reaches extra RAM via the low and high window bits.
// [RULE_05] Alternate map: 0020-004F always EPROM, 0100-0FFF decodes nothing.
// [RULE_06] Main RAM 0050-00FF always decoded in both configurations.
// [RULE_07] Stack limited to 64 bytes, 00FF down to 00C0.
// [RULE_08] User EPROM 1000-3EFF and vectors 3FF4-3FFF in both configurations.
// [RULE_09] Default map adds EPROM 0100-0FFF unless high window selects RAM.
// [RULE_10] Bootloader ROM decoded at 3F00-3FEF.
// [RULE_11] 3FF0 and 3FF1 decode to mask option locations.
// [RULE_12] I/O registers decode within 0000-001F, except listed exceptions.
// [RULE_13] Port D direction slot 0007 decoded only in default configuration.
// [RULE_14] Sensitivity bit 1 selects edge-and-level, 0 edge-only triggering.
// [RULE_15] Reset sets sensitivity bit; only first write after reset counts.
// [RULE_16] Enabled security blocks external EPROM access in every mode.
// [RULE_17] One-time-programmable variants keep security permanently enabled; the code still clears it when reset_n is asserted.
// [RULE_18] Low window bit read/write; 1 routes 0020-004F to RAM, else EPROM.
// [RULE_19] Compatibility select: 1 alternate, 0 default configuration.
// [RULE_20] During power-on reset the default configuration is always used.
// [RULE_21] Alternate map 0100-0FFF: writes ignored, reads undefined.
// [RULE_22] Alternate configuration: option register ignores writes.

package memory_map_pkg;

    localparam int ADDR_W = 14;
    localparam int DATA_W = 8;

    localparam logic [13:0] IO_LO = 14'h0000;
    localparam logic [13:0] IO_HI = 14'h001F;
    localparam logic [13:0] PORTD_DIR_ADDR = 14'h0007;
    localparam logic [13:0] WIN0_LO = 14'h0020;
    localparam logic [13:0] WIN0_HI = 14'h004F;
    localparam logic [13:0] RAM_LO = 14'h0050;
    localparam logic [13:0] RAM_HI = 14'h00FF;
    localparam logic [13:0] STACK_LO = 14'h00C0;
    localparam logic [13:0] STACK_HI = 14'h00FF;
    localparam logic [13:0] WIN1_LO = 14'h0100;
    localparam logic [13:0] WIN1_HI = 14'h017F;
    localparam logic [13:0] LOW_EPROM_LO = 14'h0100;
    localparam logic [13:0] LOW_EPROM_HI = 14'h0FFF;
    localparam logic [13:0] EPROM_LO = 14'h1000;
    localparam logic [13:0] EPROM_HI = 14'h3EFF;
    localparam logic [13:0] BOOT_LO = 14'h3F00;
    localparam logic [13:0] BOOT_HI = 14'h3FEF;
    localparam logic [13:0] OPTION_ADDR = 14'h3FDF;
    localparam logic [13:0] MASK_OPT_LO = 14'h3FF0;
    localparam logic [13:0] MASK_OPT_HI = 14'h3FF1;
    localparam logic [13:0] VECT_LO = 14'h3FF4;
    localparam logic [13:0] VECT_HI = 14'h3FFF;

    // Window RAM is a separate physical array of 48 + 128 bytes.
    localparam int WRAM_DEPTH = 176;
    localparam int WRAM_AW = 8;
    localparam logic [7:0] WIN0_BASE = 8'h00;
    localparam logic [7:0] WIN1_BASE = 8'h30;

    // Option register field positions and reset values.
    localparam int OPT_LOW_WIN_BIT = 0;
    localparam int OPT_HIGH_WIN_BIT = 1;
    localparam int OPT_SENSE_BIT = 7;
    localparam logic OPT_LOW_WIN_RST = 1'b0;
    localparam logic OPT_HIGH_WIN_RST = 1'b0;
    localparam logic OPT_SENSE_RST = 1'b1;

    localparam logic [7:0] UNUSED_READ = 8'hFF;

    typedef enum logic [8:0] {
        SEL_NONE = 9'h001,
        SEL_IO = 9'h002,
        SEL_RAM = 9'h004,
        SEL_WRAM = 9'h008,
        SEL_EPROM = 9'h010,
        SEL_BOOT = 9'h020,
        SEL_OPTION = 9'h040,
        SEL_MASK_OPT = 9'h080,
        SEL_VECTOR = 9'h100
    } region_t;

    function automatic logic inRange(
        input logic [13:0] a,
        input logic [13:0] lo,
        input logic [13:0] hi
    );
        inRange = (a >= lo) && (a <= hi);
    endfunction : inRange

endpackage : memory_map_pkg

// ---- logic/window_ram.sv ----
// Window RAM array holding the two switchable RAM areas.
// Assumes one synchronous port; read data comes from a register.
`timescale 1ns/10ps

module window_ram (
    input wire logic clk,
    input wire logic writeEn,
    input wire logic [memory_map_pkg::WRAM_AW-1:0] addr,
    input wire logic [memory_map_pkg::DATA_W-1:0] writeData,
    output logic [memory_map_pkg::DATA_W-1:0] readData
);
    import memory_map_pkg::*;

    logic [DATA_W-1:0] mem [WRAM_DEPTH];

    always_ff @(posedge clk) begin
        if (writeEn) begin
            mem[addr] <= writeData;
        end
        readData <= mem[addr];
    end

endmodule : window_ram

// ---- logic/memory_map_decoder.sv ----
// Memory map decoder with option register for a 16-Kbyte address space.
// Assumes the CPU presents address, strobes and data synchronous to clk.
`timescale 1ns/10ps

module memory_map_decoder (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic powerOnReset,
    input wire logic compat_config_select,
    input wire logic securityEnable,
    input wire logic otpVariant,
    input wire logic externalAccess,
    input wire logic eraseDone,
    input wire logic busValid,
    input wire logic busWrite,
    input wire logic [memory_map_pkg::ADDR_W-1:0] busAddr,
    input wire logic [memory_map_pkg::DATA_W-1:0] busWriteData,
    output logic [memory_map_pkg::DATA_W-1:0] busReadData,
    output logic [8:0] regionSel,
    output logic portDirSel,
    output logic stackHit,
    output logic eprompBlocked,
    output logic altConfig,
    output logic low_window_ram_select,
    output logic high_window_ram_select,
    output logic irqEdgeLevel
);
    import memory_map_pkg::*;

    // ------------------------------------------------------------------
    // Option register state
    // ------------------------------------------------------------------
    logic lowWin_r, lowWin_nxt;
    logic highWin_r, highWin_nxt;
    logic sense_r, sense_nxt;
    logic senseWritten_r, senseWritten_nxt;
    logic secure_r, secure_nxt;
    logic configAlt_r, configAlt_nxt;
    region_t region;
    logic optWrite;

    // The configuration is sampled every cycle but held at default while
    // power-on reset is active, so a strap change never glitches the map.
    always_comb begin
        configAlt_nxt = compat_config_select; // [RULE_19]
        if (powerOnReset) begin
            configAlt_nxt = 1'b0; // [RULE_20]
        end
    end

    assign optWrite = busValid && busWrite && (region == SEL_OPTION)
        && !configAlt_r; // [RULE_22]

    always_comb begin
        lowWin_nxt = lowWin_r;
        highWin_nxt = highWin_r;
        sense_nxt = sense_r;
        senseWritten_nxt = senseWritten_r;
        if (optWrite) begin
            lowWin_nxt = busWriteData[OPT_LOW_WIN_BIT]; // [RULE_18] [RULE_02]
            highWin_nxt = busWriteData[OPT_HIGH_WIN_BIT]; // [RULE_03]
            if (!senseWritten_r) begin
                sense_nxt = busWriteData[OPT_SENSE_BIT]; // [RULE_15]
                senseWritten_nxt = 1'b1; // [RULE_15]
            end
        end
    end

    // Security latches on and is cleared by reset_n or by an erase; an erase never
    // clears it on OTP parts because they cannot be erased.
    always_comb begin
        secure_nxt = secure_r | securityEnable; // [RULE_16]
        if (eraseDone && !otpVariant) begin
            secure_nxt = securityEnable; // [RULE_17]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lowWin_r <= OPT_LOW_WIN_RST;
            highWin_r <= OPT_HIGH_WIN_RST;
            sense_r <= OPT_SENSE_RST; // [RULE_15]
            senseWritten_r <= 1'b0;
            secure_r <= 1'b0;
            configAlt_r <= 1'b0; // [RULE_20]
        end else begin
            lowWin_r <= lowWin_nxt;
            highWin_r <= highWin_nxt;
            sense_r <= sense_nxt;
            senseWritten_r <= senseWritten_nxt;
            secure_r <= secure_nxt;
            configAlt_r <= configAlt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    always_comb begin
        region = SEL_NONE;
        if (inRange(busAddr, IO_LO, IO_HI)) begin
            region = SEL_IO; // [RULE_12]
        end else if (inRange(busAddr, WIN0_LO, WIN0_HI)) begin
            if (lowWin_r && !configAlt_r) begin
                region = SEL_WRAM; // [RULE_04] [RULE_18]
            end else begin
                region = SEL_EPROM; // [RULE_05]
            end
        end else if (inRange(busAddr, RAM_LO, RAM_HI)) begin
            region = SEL_RAM; // [RULE_06]
        end else if (inRange(busAddr, LOW_EPROM_LO, LOW_EPROM_HI)) begin
            if (configAlt_r) begin
                region = SEL_NONE; // [RULE_05] [RULE_21]
            end else if (highWin_r && inRange(busAddr, WIN1_LO, WIN1_HI)) begin
                region = SEL_WRAM; // [RULE_03] [RULE_04]
            end else begin
                region = SEL_EPROM; // [RULE_09]
            end
        end else if (inRange(busAddr, EPROM_LO, EPROM_HI)) begin
            region = SEL_EPROM; // [RULE_08]
        end else if (busAddr == OPTION_ADDR) begin
            region = SEL_OPTION; // [RULE_02]
        end else if (inRange(busAddr, BOOT_LO, BOOT_HI)) begin
            region = SEL_BOOT; // [RULE_10]
        end else if (inRange(busAddr, MASK_OPT_LO, MASK_OPT_HI)) begin
            region = SEL_MASK_OPT; // [RULE_11]
        end else if (inRange(busAddr, VECT_LO, VECT_HI)) begin
            region = SEL_VECTOR; // [RULE_08]
        end
    end

    // The option address sits inside the boot ROM range; it is checked
    // first so the register wins, and in the alternate configuration the
    // boot ROM region is selected there instead.
    logic [8:0] regionOut;
    always_comb begin
        regionOut = region;
        if (region == SEL_OPTION && configAlt_r) begin
            regionOut = SEL_BOOT;
        end
        if (regionOut == SEL_EPROM && secure_r && externalAccess) begin
            regionOut = SEL_NONE; // [RULE_16]
        end
    end

    assign regionSel = busValid ? regionOut : SEL_NONE; // [RULE_01]
    assign portDirSel = busValid && (busAddr == PORTD_DIR_ADDR)
        && !configAlt_r; // [RULE_13]
    assign stackHit = busValid
        && inRange(busAddr, STACK_LO, STACK_HI); // [RULE_07]
    assign eprompBlocked = secure_r && externalAccess; // [RULE_16]
    assign altConfig = configAlt_r;
    assign low_window_ram_select = lowWin_r;
    assign high_window_ram_select = highWin_r;
    assign irqEdgeLevel = sense_r; // [RULE_14]

    // ------------------------------------------------------------------
    // Window RAM and read data
    // ------------------------------------------------------------------
    logic [WRAM_AW-1:0] wramAddr;
    logic [DATA_W-1:0] wramData;
    logic wramWrite;
    logic [DATA_W-1:0] readData_r, readData_nxt;

    always_comb begin
        if (busAddr < WIN1_LO) begin
            wramAddr = WIN0_BASE + 8'(busAddr - WIN0_LO);
        end else begin
            wramAddr = WIN1_BASE + 8'(busAddr - WIN1_LO);
        end
    end

    assign wramWrite = busValid && busWrite && (regionOut == SEL_WRAM);

    window_ram uWram (
        .clk(clk),
        .writeEn(wramWrite),
        .addr(wramAddr),
        .writeData(busWriteData),
        .readData(wramData)
    );

    logic readWram_r, readWram_nxt;

    always_comb begin
        readWram_nxt = busValid && !busWrite && (regionOut == SEL_WRAM);
        readData_nxt = UNUSED_READ; // [RULE_21]
        if (busValid && !busWrite && regionOut == SEL_OPTION) begin
            readData_nxt = 8'h00;
            readData_nxt[OPT_LOW_WIN_BIT] = lowWin_r;
            readData_nxt[OPT_HIGH_WIN_BIT] = highWin_r;
            readData_nxt[OPT_SENSE_BIT] = sense_r;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readData_r <= 8'h00;
            readWram_r <= 1'b0;
        end else begin
            readData_r <= readData_nxt;
            readWram_r <= readWram_nxt;
        end
    end

    assign busReadData = readWram_r ? wramData : readData_r;

endmodule : memory_map_decoder

// ---- dv/memory_map_decoder_checker.sv ----
// Concurrent checks on the memory map decoder ports.
// Assumes one clock domain and the decoder's own port names.
`timescale 1ns/10ps

module memory_map_decoder_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic powerOnReset,
    input wire logic busValid,
    input wire logic busWrite,
    input wire logic [13:0] busAddr,
    input wire logic [7:0] busWriteData,
    input wire logic [8:0] regionSel,
    input wire logic portDirSel,
    input wire logic stackHit,
    input wire logic eprompBlocked,
    input wire logic altConfig,
    input wire logic low_window_ram_select,
    input wire logic high_window_ram_select,
    input wire logic irqEdgeLevel
);
    logic wrDone_r;
    logic optWr;
    assign optWr = busValid && busWrite && busAddr == 14'h3FDF;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Only reset clears this, so a second write is told from the first.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            wrDone_r <= 1'b0;
        else if (optWr && !altConfig)
            wrDone_r <= 1'b1;
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence firstOptWr;
        optWr && !altConfig && !wrDone_r;
    endsequence
    sequence laterOptWr;
        optWr && !altConfig && wrDone_r;
    endsequence
    chk_sense_first: assert property (
        firstOptWr |=> irqEdgeLevel == $past(busWriteData[7]))
        else $error("sense bit missed first write");
    chk_sense_once: assert property (
        laterOptWr |=> $stable(irqEdgeLevel))
        else $error("sense bit took a later write");
    chk_win_write: assert property (
        optWr && !altConfig |=> {high_window_ram_select,
        low_window_ram_select} == $past(busWriteData[1:0]))
        else $error("window bits not written");
    chk_alt_lock: assert property (
        optWr && altConfig |=> $stable({high_window_ram_select,
        low_window_ram_select, irqEdgeLevel}))
        else $error("option changed in alternate map");
    chk_por_default: assert property (
        powerOnReset |=> !altConfig)
        else $error("alternate map during power-on");
    chk_win_route: assert property (
        !altConfig && busValid && !eprompBlocked
        && busAddr inside {[14'h0100:14'h017F]} |-> regionSel
        == (high_window_ram_select ? 9'h008 : 9'h010))
        else $error("high window routed wrongly");
    chk_stack_range: assert property (
        stackHit == (busValid && busAddr inside {[14'h00C0:14'h00FF]}))
        else $error("stack flag wrong");
    chk_portdir_cfg: assert property (
        busValid && busAddr == 14'h0007 |-> portDirSel == !altConfig)
        else $error("direction slot decode wrong");
endmodule : memory_map_decoder_checker

bind memory_map_decoder memory_map_decoder_checker chk_u (.*);

// ---- dv/cpu_bus_model.sv ----
// CPU bus master model issuing one byte access at a time.
// Assumes requests launch on falling clk edges.
`timescale 1ns/10ps

module cpu_bus_model (
    input wire logic clk,
    input wire logic [8:0] regionSel,
    input wire logic [7:0] busReadData,
    output logic busValid = 1'b0,
    output logic busWrite = 1'b0,
    output logic [13:0] busAddr = 14'h0000,
    output logic [7:0] busWriteData = 8'h00
);
    // Idle address and data lines carry inverted values so stale data never looks valid.
    task automatic acc(input logic w, input logic [13:0] a,
        input logic [7:0] d, output logic [8:0] rs, output logic [7:0] rd);
        @(negedge clk);
        busValid = 1'b1;
        busWrite = w;
        busAddr = a;
        busWriteData = d;
        #1 rs = regionSel;
        @(negedge clk);
        rd = busReadData;
        busValid = 1'b0;
        busAddr = ~a;
        busWriteData = ~d;
    endtask : acc
endmodule : cpu_bus_model

// ---- dv/memory_map_decoder_tb.sv ----
// Directed bench for the memory map decoder.
// Assumes cpu_bus_model makes every CPU access.
`timescale 1ns/10ps

module memory_map_decoder_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic powerOnReset = 1'b1;
    logic compat_config_select = 1'b1;
    logic securityEnable = 1'b0;
    logic otpVariant = 1'b0;
    logic externalAccess = 1'b1;
    logic eraseDone = 1'b0;
    logic busValid, busWrite, portDirSel, stackHit, eprompBlocked;
    logic altConfig, low_window_ram_select, high_window_ram_select;
    logic irqEdgeLevel;
    logic [13:0] busAddr;
    logic [7:0] busWriteData, busReadData, rd;
    logic [8:0] regionSel, rs;
    int num_errors = 0;
    int compares = 0;
    logic [13:0] ad [16] = '{14'h0000, 14'h0007, 14'h001F, 14'h0020,
        14'h004F, 14'h0050, 14'h00FF, 14'h0100, 14'h0FFF, 14'h1000,
        14'h3EFF, 14'h3F00, 14'h3FDF, 14'h3FF1, 14'h3FF4, 14'h3FFF};
    logic [8:0] rg [16] = '{9'h002, 9'h002, 9'h002, 9'h010, 9'h010,
        9'h004, 9'h004, 9'h010, 9'h010, 9'h010, 9'h010, 9'h020,
        9'h040, 9'h080, 9'h100, 9'h100};

    always #2.5 clk = ~clk;
    memory_map_decoder dut_u (
        .clk(clk),
        .reset_n(reset_n),
        .powerOnReset(powerOnReset),
        .compat_config_select(compat_config_select),
        .securityEnable(securityEnable),
        .otpVariant(otpVariant),
        .externalAccess(externalAccess),
        .eraseDone(eraseDone),
        .busValid(busValid),
        .busWrite(busWrite),
        .busAddr(busAddr),
        .busWriteData(busWriteData),
        .busReadData(busReadData),
        .regionSel(regionSel),
        .portDirSel(portDirSel),
        .stackHit(stackHit),
        .eprompBlocked(eprompBlocked),
        .altConfig(altConfig),
        .low_window_ram_select(low_window_ram_select),
        .high_window_ram_select(high_window_ram_select),
        .irqEdgeLevel(irqEdgeLevel)
    );
    cpu_bus_model cpu (
        .clk(clk),
        .regionSel(regionSel),
        .busReadData(busReadData),
        .busValid(busValid),
        .busWrite(busWrite),
        .busAddr(busAddr),
        .busWriteData(busWriteData)
    );
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [8:0] got, exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", n, exp, got);
        end
    endtask : chk
    task automatic readByte(input logic [13:0] a);
        cpu.acc(1'b0, a, 8'h00, rs, rd);
    endtask : readByte
    task automatic writeByte(input logic [13:0] a, input logic [7:0] d);
        cpu.acc(1'b1, a, d, rs, rd);
    endtask : writeByte
    task automatic win(input logic [1:0] e);
        chk("win", 9'({high_window_ram_select, low_window_ram_select}),
            9'(e));
    endtask : win
    task automatic test_done;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task automatic pulse_erase;
        eraseDone = 1'b1;
        @(negedge clk);
        eraseDone = 1'b0;
        @(negedge clk);
    endtask : pulse_erase
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        chk("alt", 9'(altConfig), 9'h000);
        chk("sense", 9'(irqEdgeLevel), 9'h001);
        win(2'b00);
        powerOnReset = 1'b0;
        compat_config_select = 1'b0;
        readByte(14'h3FDF);
        chk("opt", 9'(rd), 9'h080);
        for (int i = 0; i < 16; i++) begin
            readByte(ad[i]);
            chk("map", rs, rg[i]);
        end
        readByte(14'h3FEF);
        chk("map", rs, 9'h020);
        readByte(14'h3FF0);
        chk("map", rs, 9'h080);
        writeByte(14'h3FDF, 8'h03);
        chk("sense", 9'(irqEdgeLevel), 9'h000);
        writeByte(14'h3FDF, 8'h81);
        chk("sense", 9'(irqEdgeLevel), 9'h000);
        win(2'b01);
        readByte(14'h0020);
        chk("map", rs, 9'h008);
        writeByte(14'h3FDF, 8'h02);
        readByte(14'h0020);
        chk("map", rs, 9'h010);
        readByte(14'h0180);
        chk("map", rs, 9'h010);
        writeByte(14'h3FDF, 8'h03);
        writeByte(14'h0020, 8'hA5);
        writeByte(14'h017F, 8'h5A);
        readByte(14'h0020);
        chk("ram", 9'(rd), 9'h0A5);
        readByte(14'h017F);
        chk("ram", 9'(rd), 9'h05A);
        compat_config_select = 1'b1;
        repeat (2) @(negedge clk);
        chk("alt", 9'(altConfig), 9'h001);
        readByte(14'h0020);
        chk("map", rs, 9'h010);
        readByte(14'h0100);
        chk("map", rs, 9'h001);
        chk("unused", 9'(rd), 9'h0FF);
        writeByte(14'h3FDF, 8'h00);
        chk("map", rs, 9'h020);
        readByte(14'h0007);
        win(2'b11);
        compat_config_select = 1'b0;
        securityEnable = 1'b1;
        @(negedge clk);
        securityEnable = 1'b0;
        @(negedge clk);
        chk("block", 9'(eprompBlocked), 9'h001);
        readByte(14'h1000);
        chk("map", rs, 9'h001);
        externalAccess = 1'b0;
        readByte(14'h1000);
        chk("map", rs, 9'h010);
        externalAccess = 1'b1;
        otpVariant = 1'b1;
        pulse_erase();
        chk("block", 9'(eprompBlocked), 9'h001);
        otpVariant = 1'b0;
        pulse_erase();
        chk("block", 9'(eprompBlocked), 9'h000);
        reset_n = 1'b0;
        @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        chk("sense", 9'(irqEdgeLevel), 9'h001);
        win(2'b00);
        writeByte(14'h3FDF, 8'h00);
        chk("sense", 9'(irqEdgeLevel), 9'h000);
        writeByte(14'h3FDF, 8'h80);
        chk("sense", 9'(irqEdgeLevel), 9'h000);
        test_done();
    end
    initial begin
        repeat (2000) @(posedge clk);
        num_errors++;
        test_done();
    end
endmodule : memory_map_decoder_tb
